// ---- design/ibs_pkg.sv ----
`default_nettype none
package ibs_pkg;
  typedef logic [15:0] ibs_word_t;
  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_DOWN} ibs_pwr_e;

  // command word layout
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned CMD_WR_BIT = 15;

  // byte addresses on the configuration page
  localparam logic [6:0] ADDR_PAGE = 7'h00;
  localparam logic [6:0] ADDR_GLOB = 7'h02;
  localparam logic [6:0] ADDR_BIAS = 7'h0E;
  localparam logic [6:0] ADDR_SLEEP = 7'h10;
  localparam logic [6:0] ADDR_FLT0 = 7'h16;
  localparam logic [6:0] ADDR_FLT1 = 7'h18;
  localparam logic [6:0] ADDR_ALM0 = 7'h20;
  localparam logic [7:0] CFG_PAGE = 8'h03;

  // reset values and writable masks
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam ibs_word_t BIAS_RST = 16'h070A;
  localparam ibs_word_t BIAS_MASK = 16'h3F0F;
  localparam ibs_word_t SLP_RST = 16'h0000;
  localparam ibs_word_t SLP_MASK = 16'h03FF;
  localparam ibs_word_t FLT0_RST = 16'h0000;
  localparam ibs_word_t FLT0_MASK = 16'h7FFF;
  localparam ibs_word_t FLT1_RST = 16'h0000;
  localparam ibs_word_t FLT1_MASK = 16'h0007;
  localparam ibs_word_t ALM0_RST = 16'h0000;
  localparam ibs_word_t ALM0_MASK = 16'hBBBB;

  // field positions
  localparam logic [3:0] TBC_MAX = 4'hD;
  localparam int unsigned GLOB_BIAS_BIT = 0;
  localparam int unsigned SLP_SLEEP_BIT = 8;
  localparam int unsigned SLP_PD_BIT = 9;

  // timing
  localparam int unsigned MCLK_HZ = 50_000_000;
  localparam int unsigned BURST_RATE_HZ = 9840;
  localparam int unsigned BURST_LEN = 4;
  localparam int unsigned SLEEP_LSB_SEC = 1;
  localparam int unsigned BURST_CYC_DEF = MCLK_HZ / BURST_RATE_HZ;
  localparam int unsigned SEC_CYC_DEF = MCLK_HZ * SLEEP_LSB_SEC;

  // dynamic alarm windows
  localparam int unsigned ALM_AVG = 8;
  localparam int unsigned ALM_LAG = 112;
endpackage
`default_nettype wire

// ---- design/ibs_alarm_chan.sv ----
`default_nettype none
module ibs_alarm_chan #(
  parameter int unsigned W = 16,
  parameter int unsigned LAG = ibs_pkg::ALM_LAG
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sampleValid,
  input wire logic signed [W-1:0] sample,
  input wire logic signed [W-1:0] threshold,
  input wire logic enable,
  input wire logic [1:0] cond,
  input wire logic clear,
  output logic flag
);
  import ibs_pkg::*;
  localparam int unsigned DEPTH = LAG + ALM_AVG;
  localparam int unsigned PW = $clog2(DEPTH);

  if (LAG < ALM_AVG || W < 2) begin : g_chk
    $error("alarm lag must cover the averaging window");
  end

  logic signed [W-1:0] hist_r [DEPTH];
  logic [PW-1:0] ptr_r;
  logic signed [W+3:0] sumNew_r, sumOld_r, sumNewNxt, sumOldNxt, delta, valX, thrX;
  logic hit;

  function automatic logic [PW-1:0] idx(input logic [PW-1:0] p, input int unsigned back);
    int unsigned t;
    t = (int'(p) + DEPTH - back) % DEPTH;
    return PW'(t);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // running sums of newest and lagged windows
  always_comb begin
    valX = (W+4)'(sample);
    thrX = (W+4)'(threshold);
    sumNewNxt = sumNew_r + valX - (W+4)'(hist_r[idx(ptr_r, ALM_AVG)]);
    sumOldNxt = sumOld_r + (W+4)'(hist_r[idx(ptr_r, LAG)]) - (W+4)'(hist_r[ptr_r]);
    delta = (sumNewNxt - sumOldNxt) >>> 3;
    case (cond)
      2'h0: hit = valX < thrX;
      2'h1: hit = delta < thrX;
      2'h2: hit = valX > thrX;
      default: hit = delta > thrX;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist_r[i] <= '0;
      end
      ptr_r <= '0;
      sumNew_r <= '0;
      sumOld_r <= '0;
    end else if (ce && sampleValid) begin
      hist_r[ptr_r] <= sample;
      ptr_r <= (int'(ptr_r) == DEPTH - 1) ? '0 : ptr_r + PW'(1);
      sumNew_r <= sumNewNxt;
      sumOld_r <= sumOldNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky flag, a new hit beats a clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'h0;
    end else if (ce) begin
      if (sampleValid && enable && hit) begin
        flag <= 1'h1;
      end else if (clear) begin
        flag <= 1'h0;
      end
    end
  end

  property p_flag_set;
    @(posedge mclk) disable iff (!rst_n)
    ce && sampleValid && enable && hit |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("alarm hit did not set flag");
endmodule
`default_nettype wire

// ---- design/ibs_cfg_top.sv ----
// What this block does
// - time base field takes 0..13, default 10; averaging time 64 time bases
// - bias config bits 13..8 enable bias correction per axis, bit 8 x gyro
// - bias-update command loads bias correction of every enabled axis
// - default enables gyro axes, disables accel axes, about 26.64 s averaging
// - external pulse starts four samples at 9.84 kHz, averaged to one output
// - write-only sleep register: bit 9 power-down, bit 8 sleep, 7..0 seconds
// - power-down loses volatile settings, sleep keeps them
// - sleep starts when chip select rises after the request write
// - chip select falling, reset pin pulse or power cycle wakes the device
// - sleep and power-down requested together means sleep
// - bank select codes 00 A, 01 B, 10 C, 11 D
// - first filter register holds enable and bank per y/x accel, z/y/x gyro
// - second filter register: bit 2 enable, bits 1..0 bank for z accel
// - alarm condition: below, delta below, above, delta above threshold
// - delta is newest eight sum minus eight lagged 112, divided by eight
// - alarm config 0 enables at 15, 11, 7, 3, conditions beside them
// - enabled alarm with met condition sets its status flag
`default_nettype none
module ibs_cfg_top #(
  parameter int unsigned BURST_CYC = ibs_pkg::BURST_CYC_DEF,
  parameter int unsigned SEC_CYC = ibs_pkg::SEC_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic csN,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  input wire logic extClkMode,
  input wire logic syncPulse,
  input wire ibs_pkg::ibs_word_t xAccelSample,
  input wire ibs_pkg::ibs_word_t zGyroSample,
  input wire ibs_pkg::ibs_word_t yGyroSample,
  input wire ibs_pkg::ibs_word_t xGyroSample,
  input wire ibs_pkg::ibs_word_t xAccelThreshold,
  input wire ibs_pkg::ibs_word_t zGyroThreshold,
  input wire ibs_pkg::ibs_word_t yGyroThreshold,
  input wire ibs_pkg::ibs_word_t xGyroThreshold,
  input wire logic [3:0] alarmClear,
  output logic [3:0] alarmFlags,
  output logic sampleStrobe,
  output logic dataReady,
  output logic biasUpdate,
  output logic [5:0] biasEnable,
  output logic [3:0] timeBase,
  output logic [5:0] firEnable,
  output logic [11:0] firBank,
  output logic sleepMode,
  output logic powerDown
);
  import ibs_pkg::*;

  if (BURST_CYC < 2 || SEC_CYC < 2) begin : g_chk
    $error("cycle counts must be at least two");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin edges
  logic sclkD_r, csD_r, syncD_r;
  logic sclkRise, sclkFall, csFall, csRise, syncRise;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclkD_r <= 1'h1;
      csD_r <= 1'h1;
      syncD_r <= 1'h0;
    end else if (ce) begin
      sclkD_r <= sclk;
      csD_r <= csN;
      syncD_r <= syncPulse;
    end
  end

  assign sclkRise = sclk && !sclkD_r;
  assign sclkFall = !sclk && sclkD_r;
  assign csFall = !csN && csD_r;
  assign csRise = csN && !csD_r;
  assign syncRise = syncPulse && !syncD_r;

  ////////////////////////////////////////////////////////////////////////////////
  // serial word capture
  ibs_word_t rxShift_r, word_r;
  logic [3:0] bitCnt_r;
  logic wordValid_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxShift_r <= '0;
      word_r <= '0;
      bitCnt_r <= '0;
      wordValid_r <= 1'h0;
    end else if (ce) begin
      wordValid_r <= 1'h0;
      if (csFall) begin
        bitCnt_r <= '0;
      end else if (sclkRise && !csN) begin
        rxShift_r <= {rxShift_r[14:0], din};
        bitCnt_r <= bitCnt_r + 4'h1;
        if (bitCnt_r == 4'hF) begin
          word_r <= {rxShift_r[14:0], din};
          wordValid_r <= 1'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command decode
  ibs_pwr_e pwr_r;
  logic [7:0] page_r;
  ibs_word_t bias_r, slp_r, flt0_r, flt1_r, alm0_r, rdWord;
  logic [6:0] cmdAddr, rdAddr;
  logic [7:0] cmdData, biasByte;
  logic awake, onPage, wrStrobe, tbcOk, enterNow, wakeNow, timeUp, restore;
  logic [31:0] secCnt_r;
  logic [7:0] secLeft_r;

  assign cmdAddr = word_r[14:8];
  assign cmdData = word_r[7:0];
  assign rdAddr = {cmdAddr[6:1], 1'h0};
  assign awake = (pwr_r == PWR_RUN);
  assign onPage = (page_r == CFG_PAGE);
  assign wrStrobe = wordValid_r && word_r[CMD_WR_BIT] && awake;
  assign tbcOk = cmdAddr[0] || (cmdData[3:0] <= TBC_MAX);
  assign biasByte = tbcOk ? cmdData : {cmdData[7:4], bias_r[3:0]};

  function automatic ibs_word_t wrByte(input ibs_word_t old, input logic hi,
      input logic [7:0] d, input ibs_word_t mask);
    ibs_word_t v;
    v = hi ? {d, old[7:0]} : {old[15:8], d};
    return v & mask;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_r <= PAGE_RST;
      bias_r <= BIAS_RST;
      slp_r <= SLP_RST;
      flt0_r <= FLT0_RST;
      flt1_r <= FLT1_RST;
      alm0_r <= ALM0_RST;
    end else if (ce) begin
      if (restore) begin
        page_r <= PAGE_RST;
        bias_r <= BIAS_RST;
        slp_r <= SLP_RST;
        flt0_r <= FLT0_RST;
        flt1_r <= FLT1_RST;
        alm0_r <= ALM0_RST;
      end else begin
        if (enterNow) begin
          slp_r[SLP_PD_BIT:SLP_SLEEP_BIT] <= 2'h0;
        end
        if (wrStrobe) begin
          if (cmdAddr == ADDR_PAGE) begin
            page_r <= cmdData;
          end else if (!onPage) begin
            page_r <= page_r;
          end else if (rdAddr == ADDR_BIAS) begin
            bias_r <= wrByte(bias_r, cmdAddr[0], biasByte, BIAS_MASK);
          end else if (rdAddr == ADDR_SLEEP) begin
            slp_r <= wrByte(slp_r, cmdAddr[0], cmdData, SLP_MASK);
          end else if (rdAddr == ADDR_FLT0) begin
            flt0_r <= wrByte(flt0_r, cmdAddr[0], cmdData, FLT0_MASK);
          end else if (rdAddr == ADDR_FLT1) begin
            flt1_r <= wrByte(flt1_r, cmdAddr[0], cmdData, FLT1_MASK);
          end else if (rdAddr == ADDR_ALM0) begin
            alm0_r <= wrByte(alm0_r, cmdAddr[0], cmdData, ALM0_MASK);
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bias update command pulse
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      biasUpdate <= 1'h0;
    end else if (ce) begin
      biasUpdate <= wrStrobe && onPage && cmdAddr == ADDR_GLOB && cmdData[GLOB_BIAS_BIT];
    end
  end

  assign biasEnable = bias_r[13:8];
  assign timeBase = bias_r[3:0];
  assign firEnable = {flt1_r[2], flt0_r[14], flt0_r[11], flt0_r[8], flt0_r[5], flt0_r[2]};
  assign firBank = {flt1_r[1:0], flt0_r[13:12], flt0_r[10:9], flt0_r[7:6], flt0_r[4:3],
                    flt0_r[1:0]};

  ////////////////////////////////////////////////////////////////////////////////
  // read answer, shifted out in the following frame
  always_comb begin
    rdWord = '0;
    if (rdAddr == ADDR_PAGE) begin
      rdWord = {8'h00, page_r};
    end else if (!onPage) begin
      rdWord = '0;
    end else if (rdAddr == ADDR_BIAS) begin
      rdWord = bias_r;
    end else if (rdAddr == ADDR_FLT0) begin
      rdWord = flt0_r;
    end else if (rdAddr == ADDR_FLT1) begin
      rdWord = flt1_r;
    end else if (rdAddr == ADDR_ALM0) begin
      rdWord = alm0_r;
    end
  end

  ibs_word_t txHold_r, txShift_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txHold_r <= '0;
      txShift_r <= '0;
      dout <= 1'h0;
    end else if (ce) begin
      if (wordValid_r && !word_r[CMD_WR_BIT]) begin
        txHold_r <= rdWord;
      end
      if (csFall) begin
        txShift_r <= txHold_r;
        dout <= txHold_r[15];
      end else if (sclkFall && !csN) begin
        txShift_r <= {txShift_r[14:0], 1'h0};
        dout <= txShift_r[14];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sleep and power-down sequencing
  assign enterNow = awake && csRise && (slp_r[SLP_SLEEP_BIT] || slp_r[SLP_PD_BIT]);
  assign timeUp = (secLeft_r == 8'h01) && (secCnt_r == 32'(SEC_CYC - 1));
  assign wakeNow = !awake && (csFall || timeUp);
  assign restore = (pwr_r == PWR_DOWN) && wakeNow;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_r <= PWR_RUN;
      sleepMode <= 1'h0;
      powerDown <= 1'h0;
      secCnt_r <= '0;
      secLeft_r <= '0;
    end else if (ce) begin
      case (pwr_r)
        PWR_RUN: begin
          if (enterNow) begin
            secCnt_r <= '0;
            secLeft_r <= slp_r[7:0];
            if (slp_r[SLP_SLEEP_BIT]) begin
              pwr_r <= PWR_SLEEP;
              sleepMode <= 1'h1;
            end else begin
              pwr_r <= PWR_DOWN;
              powerDown <= 1'h1;
            end
          end
        end
        default: begin
          if (wakeNow) begin
            pwr_r <= PWR_RUN;
            sleepMode <= 1'h0;
            powerDown <= 1'h0;
          end else if (secLeft_r != 8'h00) begin
            if (secCnt_r == 32'(SEC_CYC - 1)) begin
              secCnt_r <= '0;
              secLeft_r <= secLeft_r - 8'h01;
            end else begin
              secCnt_r <= secCnt_r + 32'h1;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sample bursts and output data rate
  logic burstActive_r;
  logic [31:0] tickCnt_r;
  logic [1:0] burstIdx_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      burstActive_r <= 1'h0;
      tickCnt_r <= '0;
      burstIdx_r <= '0;
      sampleStrobe <= 1'h0;
      dataReady <= 1'h0;
    end else if (ce) begin
      sampleStrobe <= 1'h0;
      dataReady <= 1'h0;
      if (!awake) begin
        burstActive_r <= 1'h0;
        tickCnt_r <= '0;
        burstIdx_r <= '0;
      end else if (!burstActive_r) begin
        if (!extClkMode || syncRise) begin
          burstActive_r <= 1'h1;
          tickCnt_r <= '0;
        end
      end else if (tickCnt_r == 32'(BURST_CYC - 1)) begin
        tickCnt_r <= '0;
        sampleStrobe <= 1'h1;
        burstIdx_r <= burstIdx_r + 2'h1;
        if (burstIdx_r == 2'(BURST_LEN - 1)) begin
          dataReady <= 1'h1;
          burstActive_r <= !extClkMode;
        end
      end else begin
        tickCnt_r <= tickCnt_r + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // alarm channels: 3 x accel, 2 z gyro, 1 y gyro, 0 x gyro
  ibs_word_t smp [4];
  ibs_word_t thr [4];

  assign smp[3] = xAccelSample;
  assign smp[2] = zGyroSample;
  assign smp[1] = yGyroSample;
  assign smp[0] = xGyroSample;
  assign thr[3] = xAccelThreshold;
  assign thr[2] = zGyroThreshold;
  assign thr[1] = yGyroThreshold;
  assign thr[0] = xGyroThreshold;

  for (genvar i = 0; i < 4; i++) begin : g_alm
    ibs_alarm_chan #(.W(WORD_BITS), .LAG(ALM_LAG)) u_chan (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .sampleValid(dataReady),
      .sample(smp[i]),
      .threshold(thr[i]),
      .enable(alm0_r[4*i+3]),
      .cond(alm0_r[4*i +: 2]),
      .clear(alarmClear[i]),
      .flag(alarmFlags[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_tbc_range;
    @(posedge mclk) disable iff (!rst_n)
    timeBase <= TBC_MAX;
  endproperty
  a_tbc_range: assert property (p_tbc_range) else $error("time base out of range");

  property p_bias_cmd;
    @(posedge mclk) disable iff (!rst_n)
    ce && wrStrobe && onPage && cmdAddr == ADDR_GLOB && cmdData[0] |=> biasUpdate;
  endproperty
  a_bias_cmd: assert property (p_bias_cmd) else $error("bias update not issued");

  property p_sleep_on_cs;
    @(posedge mclk) disable iff (!rst_n)
    $past(awake) && !awake |-> $past(csRise && ce);
  endproperty
  a_sleep_on_cs: assert property (p_sleep_on_cs) else $error("sleep without cs rise");

  property p_wake_cs;
    @(posedge mclk) disable iff (!rst_n)
    ce && !awake && csFall |=> awake && !sleepMode && !powerDown;
  endproperty
  a_wake_cs: assert property (p_wake_cs) else $error("cs fall did not wake");

  property p_sleep_prio;
    @(posedge mclk) disable iff (!rst_n)
    ce && enterNow && slp_r[SLP_SLEEP_BIT] |=> pwr_r == PWR_SLEEP && !powerDown;
  endproperty
  a_sleep_prio: assert property (p_sleep_prio) else $error("power-down beat sleep");

  property p_pd_restore;
    @(posedge mclk) disable iff (!rst_n)
    ce && restore |=> bias_r == BIAS_RST && alm0_r == ALM0_RST && page_r == PAGE_RST;
  endproperty
  a_pd_restore: assert property (p_pd_restore) else $error("settings kept after power-down");

  property p_flt1_upper;
    @(posedge mclk) disable iff (!rst_n)
    flt1_r[15:3] == 13'h0000 && alm0_r[14] == 1'h0 && alm0_r[10] == 1'h0;
  endproperty
  a_flt1_upper: assert property (p_flt1_upper) else $error("ignored bits stored");

  property p_ready_rate;
    @(posedge mclk) disable iff (!rst_n)
    dataReady |-> sampleStrobe && $past(burstIdx_r) == 2'h3;
  endproperty
  a_ready_rate: assert property (p_ready_rate) else $error("output not after four samples");
endmodule
`default_nettype wire

// ---- testbench/ibs_spi_host.sv ----
`default_nettype none
module ibs_spi_host (
  input wire logic mclk,
  output var logic csN,
  output var logic sclk,
  output var logic din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    csN = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // one frame, msb first, sclk idle high, three mclk per sclk phase
  // dout is read just before each falling sclk, since the block moves it on that fall
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    step(1);
    csN = 1'b0;
    step(3);
    for (int i = 15; i >= 0; i--) begin
      rx[i] = dout;
      sclk = 1'b0;
      din = tx[i];
      step(3);
      sclk = 1'b1;
      step(3);
    end
    csN = 1'b1;
    din = ~din;
    step(4);
  endtask
  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [15:0] rx;
    xfer({1'b1, addr, data}, rx);
  endtask
  // answer comes back in the following frame
  task automatic rd(input logic [6:0] addr, output logic [15:0] val);
    logic [15:0] rx;
    xfer({1'b0, addr, 8'h00}, rx);
    xfer(16'h0000, val);
  endtask
endmodule
`default_nettype wire

// ---- testbench/test_ibs_cfg_top.sv ----
`default_nettype none
module test_ibs_cfg_top import ibs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst_n, ce, csN, sclk, din, dout, extClkMode, syncPulse;
  ibs_word_t xAccelSample, zGyroSample, yGyroSample, xGyroSample, thr;
  logic [3:0] alarmClear, alarmFlags, timeBase;
  logic sampleStrobe, dataReady, biasUpdate, sleepMode, powerDown;
  logic [5:0] biasEnable, firEnable;
  logic [11:0] firBank;
  logic [15:0] rx, v;
  logic [1:0] b;
  int failures = 0, comparisons = 0, cycles = 0, strobes = 0, readies = 0, updates = 0;
  int s0, r0;
  initial begin
    forever #10 mclk = ~mclk;
  end
  ibs_cfg_top #(.BURST_CYC(4), .SEC_CYC(20)) ibs_cfg_top_i (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .csN(csN), .sclk(sclk), .din(din), .dout(dout),
    .extClkMode(extClkMode), .syncPulse(syncPulse), .xAccelSample(xAccelSample),
    .zGyroSample(zGyroSample), .yGyroSample(yGyroSample), .xGyroSample(xGyroSample),
    .xAccelThreshold(thr), .zGyroThreshold(thr), .yGyroThreshold(thr),
    .xGyroThreshold(thr), .alarmClear(alarmClear), .alarmFlags(alarmFlags),
    .sampleStrobe(sampleStrobe), .dataReady(dataReady), .biasUpdate(biasUpdate),
    .biasEnable(biasEnable), .timeBase(timeBase), .firEnable(firEnable),
    .firBank(firBank), .sleepMode(sleepMode), .powerDown(powerDown)
  );
  ibs_spi_host ibs_spi_host_i (.mclk(mclk), .csN(csN), .sclk(sclk), .din(din), .dout(dout));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // event counters and hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    strobes <= strobes + int'(sampleStrobe === 1'b1);
    readies <= readies + int'(dataReady === 1'b1);
    updates <= updates + int'(biasUpdate === 1'b1);
    if (dataReady === 1'b1) check("strobeWithReady", 16'(sampleStrobe), 16'h0001);
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    extClkMode = 1'b0;
    syncPulse = 1'b0;
    alarmClear = 4'h0;
    xAccelSample = 16'h0064;
    zGyroSample = 16'h000A;
    yGyroSample = 16'h000A;
    xGyroSample = 16'h0064;
    thr = 16'h0032;
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'b1;
    step(1);
    check("biasEnable", 16'(biasEnable), 16'h0007);
    check("timeBase", 16'(timeBase), 16'h000A);
    // writes before page select are refused
    ibs_spi_host_i.wr(ADDR_FLT0, 8'h07);
    ibs_spi_host_i.rd(ADDR_FLT0, rx);
    check("firBeforePage", rx, 16'h0000);
    check("firEnableBeforePage", 16'(firEnable), 16'h0000);
    ibs_spi_host_i.wr(ADDR_PAGE, CFG_PAGE);
    ibs_spi_host_i.wr(ADDR_BIAS, 8'h0D);
    check("timeBaseMax", 16'(timeBase), 16'h000D);
    ibs_spi_host_i.wr(ADDR_BIAS, 8'h0E);
    check("timeBaseKept", 16'(timeBase), 16'h000D);
    ibs_spi_host_i.wr(7'h0F, 8'h3F);
    check("biasEnableAll", 16'(biasEnable), 16'h003F);
    ibs_spi_host_i.rd(ADDR_BIAS, rx);
    check("biasCfgRead", rx, 16'h3F0D);
    ibs_spi_host_i.wr(ADDR_GLOB, 8'h01);
    check("biasUpdatePulses", 16'(updates), 16'h0001);
    // every bank code on every axis
    for (int c = 0; c < 4; c++) begin
      b = 2'(c);
      v = {1'b0, 1'b1, b, 1'b1, b, 1'b1, b, 1'b1, b, 1'b1, b};
      ibs_spi_host_i.wr(ADDR_FLT0, v[7:0]);
      ibs_spi_host_i.wr(7'h17, v[15:8]);
      ibs_spi_host_i.wr(ADDR_FLT1, {5'h1F, 1'b1, b});
      check("firEnable", 16'(firEnable), 16'h003F);
      check("firBank", 16'(firBank), 16'({6{b}}));
      ibs_spi_host_i.rd(ADDR_FLT1, rx);
      check("firBank1Read", rx, 16'({1'b1, b}));
    end
    // static alarms: x accel above, z gyro below, y gyro above but not met
    ibs_spi_host_i.wr(ADDR_ALM0, 8'hA0);
    ibs_spi_host_i.wr(7'h21, 8'hA8);
    ibs_spi_host_i.rd(ADDR_ALM0, rx);
    check("alarmCfgRead", rx, 16'hA8A0);
    check("alarmFlagsStatic", 16'(alarmFlags), 16'h000C);
    ibs_spi_host_i.wr(7'h21, 8'h00);
    // y gyro through all conditions; constant input gives zero delta
    for (int c = 0; c < 4; c++) begin
      b = 2'(c);
      ibs_spi_host_i.wr(ADDR_ALM0, {1'b1, 1'b0, b, 4'h0});
      alarmClear = 4'hF;
      step(1);
      alarmClear = 4'h0;
      step(40);
      check("alarmCond", 16'(alarmFlags), 16'({c < 2, 1'b0}));
    end
    // external sync: one pulse, four samples, one output
    extClkMode = 1'b1;
    step(40);
    s0 = strobes;
    r0 = readies;
    syncPulse = 1'b1;
    step(2);
    syncPulse = 1'b0;
    step(60);
    check("burstStrobes", 16'(strobes - s0), 16'h0004);
    check("burstReady", 16'(readies - r0), 16'h0001);
    extClkMode = 1'b0;
    // timed sleep of three seconds
    ibs_spi_host_i.wr(ADDR_SLEEP, 8'h03);
    ibs_spi_host_i.wr(7'h11, 8'h01);
    check("sleepEntered", 16'(sleepMode), 16'h0001);
    step(40);
    check("sleepHolding", 16'(sleepMode), 16'h0001);
    step(40);
    check("sleepTimedOut", 16'(sleepMode), 16'h0000);
    // both bits, indefinite: sleep wins, woken by chip select
    ibs_spi_host_i.wr(ADDR_SLEEP, 8'h00);
    ibs_spi_host_i.wr(7'h11, 8'h03);
    step(100);
    check("bothSleep", 16'({sleepMode, powerDown}), 16'h0002);
    ibs_spi_host_i.rd(ADDR_FLT1, rx);
    check("csWake", 16'(sleepMode), 16'h0000);
    check("sleepKeepsRead", rx, 16'h0007);
    check("sleepKeepsEn", 16'(firEnable), 16'h003F);
    check("sleepKeepsBank", 16'(firBank), 16'h0FFF);
    // power-down loses the settings
    ibs_spi_host_i.wr(7'h11, 8'h02);
    check("powerDown", 16'(powerDown), 16'h0001);
    ibs_spi_host_i.rd(ADDR_FLT1, rx);
    check("pdWake", 16'(powerDown), 16'h0000);
    check("pdRead", rx, 16'h0000);
    check("pdLosesEn", 16'(firEnable), 16'h0000);
    check("pdLosesBank", 16'(firBank), 16'h0000);
    check("pdBias", 16'(biasEnable), 16'h0007);
    // reset pin pulse wakes from sleep
    ibs_spi_host_i.wr(ADDR_PAGE, CFG_PAGE);
    ibs_spi_host_i.wr(7'h11, 8'h01);
    check("sleepAgain", 16'(sleepMode), 16'h0001);
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    step(2);
    check("resetWake", 16'(sleepMode), 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
